// ---- logic/ppcs_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes byte addressing on a 32-bit APB bus, one register per word
`ifndef PPCS_REGS_SVH
`define PPCS_REGS_SVH
// Chip select configuration words, one per chip select, from 0x00 upward
`define PPCS_CFG_BASE 8'h00
`define PPCS_CTRL_OFF 8'h10
`define PPCS_CMD_OFF 8'h14
`define PPCS_STAT_OFF 8'h18
// Configuration word fields
`define PPCS_CFG_WIDTH 16
`define PPCS_CFG_RESET 16'h0000
`define PPCS_CFG_MASK 16'hF7E0
// Control word fields
`define PPCS_CTRL_MASTER_BIT 0
// Command word fields
`define PPCS_CMD_WRITE_BIT 8
`define PPCS_CMD_LANE_LO 16
// Status word fields
`define PPCS_STAT_BUSY_BIT 0
`define PPCS_STAT_DONE_BIT 1
`define PPCS_STAT_REFUSED_BIT 2
`define PPCS_STAT_TIMEOUT_BIT 3
// Timing counts in clock cycles
`define PPCS_STROBE_CYCLES 4
`define PPCS_ACK_WAIT_CYCLES 16
`endif

// ---- logic/ppcs_pkg.sv ----
// Types shared by the chip select configuration block
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ppcs_pkg;
  // One chip select configuration word, bit 15 down to bit 0
  typedef struct packed {
    logic cs_off;                // Chip select function off
    logic cs_polarity;           // Chip select active high
    logic cs_pin_drive_on;       // Pin used as chip select output
    logic lane_enable_polarity;  // Lane enables active high
    logic unused_11;             // Reads as zero
    logic write_strobe_polarity; // Write or enable strobe active high
    logic read_strobe_polarity;  // Read or read/write strobe active high
    logic strobe_style;          // Combined strobe plus enable strobe
    logic ack_polarity;          // Acknowledge active high
    logic port_size_hi;          // Port size, upper bit
    logic port_size_lo;          // Port size, lower bit
    logic [4:0] unused_low;      // Read as zero
  } ppcs_cfg_type;
  // Strobe and lane pins toward the peripheral
  typedef struct packed {
    logic lane_enable_0;     // Lower lane enable
    logic lane_enable_1;     // Upper lane enable
    logic write_strobe_out;  // Write strobe
    logic read_strobe_out;   // Read strobe or read/write line
    logic enable_strobe_out; // Enable strobe
  } ppcs_pins_type;
  // Bus cycle engine states
  typedef enum logic [1:0] {PPCS_IDLE, PPCS_STROBE, PPCS_ACK} ppcs_state_type;
endpackage : ppcs_pkg
`default_nettype wire

// ---- logic/ppcs_port.sv ----
// Chip select configuration and bus cycle engine of a parallel port
// Assumes an APB master on clk and an external peripheral on the pins
//
// Notes on behaviour
// R01: Disable bit turns chip select off
// R02: Polarity bit sets chip select active level
// R03: Drive pin only when port enable set
// R04: Lane enables follow enable polarity bit
// R05: Write polarity sets write strobe level
// R06: Master style one: write polarity sets enable
// R07: Read polarity sets read strobe level
// R08: Master style one: read polarity sets read/write
// R09: Style one combined strobe, zero separate strobes
// R10: Acknowledge input level follows its polarity bit
// R11: Each chip select keeps own settings
//
// Implementation choices: the APB interface to the registers and the register addresses.
`include "ppcs_regs.svh"
`default_nettype none
module ppcs_port import ppcs_pkg::*; #(
  parameter int NUM_CS = 2,                              // Chip selects
  parameter int STROBE_CYCLES = `PPCS_STROBE_CYCLES,     // Strobe length
  parameter int ACK_WAIT_CYCLES = `PPCS_ACK_WAIT_CYCLES  // Acknowledge wait
) (
  input wire logic clk,                            // 25 MHz clock
  input wire logic reset_n,                        // Synchronous reset
  input wire logic psel,                           // APB select
  input wire logic penable,                        // APB enable
  input wire logic pwrite,                         // APB direction
  input wire logic [7:0] paddr,                    // APB byte address
  input wire logic [31:0] pwdata,                  // APB write data
  output logic [31:0] prdata,                      // APB read data
  output logic pready,                             // APB ready
  output logic pslverr,                            // APB error
  output logic [NUM_CS-1:0] chip_select_out,       // Chip select levels
  output logic [NUM_CS-1:0] chip_select_oe_n,      // Chip select drive, low
  output ppcs_pins_type bus_pins,                  // Strobes and lanes
  input wire logic ack_in                          // Acknowledge pin
);
  localparam int IDX_W = (NUM_CS > 1) ? $clog2(NUM_CS) : 1;
  localparam int CNT_W = 8;

  // Word index of a configuration register, or NUM_CS if none
  function automatic int cfg_index(input logic [7:0] addr);
    int idx;
    idx = NUM_CS;
    for (int i = 0; i < NUM_CS; i++) begin
      if (addr == 8'(`PPCS_CFG_BASE + 4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction : cfg_index

  // Level of a pin given its active-high polarity and whether active
  function automatic logic pin_level(input logic pol, input logic active);
    return active ? pol : ~pol;
  endfunction : pin_level

  // Register state
  ppcs_cfg_type cfg [NUM_CS];          // Per chip select settings
  ppcs_cfg_type next_cfg [NUM_CS];
  logic master_mode, next_master_mode; // Master when set
  logic [2:0] stat, next_stat;         // Timeout, refused, done flags
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  // Engine state
  ppcs_state_type state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;     // Phase counter
  logic [IDX_W-1:0] sel, next_sel;     // Chip select of the cycle
  logic is_write, next_is_write;       // Cycle direction
  logic [1:0] lanes, next_lanes;       // Lanes of the cycle
  // Pin outputs
  logic [NUM_CS-1:0] next_cs_out, next_cs_oe_n;
  ppcs_pins_type next_pins;
  // Acknowledge synchroniser
  logic ack_s1, ack_s2, ack_s3, ack_level, next_ack_level;
  logic ack_active;
  // Bus decode
  logic apb_access, apb_wr, apb_rd, cmd_wr;
  int widx;
  ppcs_cfg_type scfg;                  // Settings of the cycle's chip select
  logic style_one;                     // Combined strobe in use

  assign apb_access = psel & penable & pready;
  assign apb_wr = apb_access & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign cmd_wr = apb_wr & (paddr == `PPCS_CMD_OFF);
  assign widx = cfg_index(paddr);
  assign scfg = cfg[sel];
  assign style_one = master_mode & scfg.strobe_style; // R09
  assign ack_active = (ack_level == scfg.ack_polarity); // R10

  // Acknowledge: a change counts once second and third stage agree
  always_comb begin
    next_ack_level = (ack_s2 == ack_s3) ? ack_s3 : ack_level;
  end

  always_ff @(posedge clk) begin
    ack_s1 <= ack_in;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
    if (!reset_n) begin
      ack_level <= 1'b0;
    end else begin
      ack_level <= next_ack_level;
    end
  end

  // Register writes, status flags and APB answer
  always_comb begin
    next_cfg = cfg;
    next_master_mode = master_mode;
    next_stat = stat;
    next_prdata = 32'h0000_0000;
    next_pready = psel & ~penable;
    next_pslverr = 1'b0;
    // Software clears status by writing ones
    if (apb_wr && paddr == `PPCS_STAT_OFF) begin
      next_stat = stat & ~pwdata[`PPCS_STAT_TIMEOUT_BIT:`PPCS_STAT_DONE_BIT];
    end
    if (apb_wr && widx < NUM_CS) begin
      next_cfg[widx] = ppcs_cfg_type'(pwdata[15:0] & `PPCS_CFG_MASK); // R11
    end
    if (apb_wr && paddr == `PPCS_CTRL_OFF) begin
      next_master_mode = pwdata[`PPCS_CTRL_MASTER_BIT];
    end
    // Engine events win over a clear in the same cycle
    if (cmd_wr && (state != PPCS_IDLE || cfg[pwdata[IDX_W-1:0]].cs_off)) begin
      next_stat[1] = 1'b1; // R01
    end
    if (state == PPCS_ACK && (ack_active || cnt == '0)) begin
      next_stat[0] = 1'b1;
    end
    if (state == PPCS_ACK && !ack_active && cnt == '0) begin
      next_stat[2] = 1'b1;
    end
    // Read data captured in setup, answered in the access phase
    if (psel && !penable) begin
      if (widx < NUM_CS) begin
        next_prdata = {16'h0000, cfg[widx]};
      end else if (paddr == `PPCS_CTRL_OFF) begin
        next_prdata = {31'h0000_0000, master_mode};
      end else if (paddr == `PPCS_STAT_OFF) begin
        next_prdata = {28'h000_0000, stat, state != PPCS_IDLE};
      end else if (paddr != `PPCS_CMD_OFF) begin
        next_pslverr = 1'b1;
      end
    end
    if (!apb_rd) begin
      next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CS; i++) begin
        cfg[i] <= ppcs_cfg_type'(`PPCS_CFG_RESET);
      end
      master_mode <= 1'b0;
      stat <= 3'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      master_mode <= next_master_mode;
      stat <= next_stat;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Bus cycle engine: strobe phase, then wait for acknowledge
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sel = sel;
    next_is_write = is_write;
    next_lanes = lanes;
    case (state)
      PPCS_IDLE: begin
        // A command to a chip select that is off starts nothing
        if (cmd_wr && !cfg[pwdata[IDX_W-1:0]].cs_off) begin // R01
          next_state = PPCS_STROBE;
          next_sel = pwdata[IDX_W-1:0];
          next_is_write = pwdata[`PPCS_CMD_WRITE_BIT];
          next_lanes = pwdata[`PPCS_CMD_LANE_LO +: 2];
          next_cnt = CNT_W'(STROBE_CYCLES - 1);
        end
      end
      PPCS_STROBE: begin
        if (cnt == '0) begin
          next_state = PPCS_ACK;
          next_cnt = CNT_W'(ACK_WAIT_CYCLES - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      PPCS_ACK: begin
        if (ack_active || cnt == '0) begin // R10
          next_state = PPCS_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = PPCS_IDLE;
      end
    endcase
  end

  // Pin levels: chip selects from their own settings, strobes and lanes from the cycle's chip select
  always_comb begin
    logic busy, strobing;
    busy = (state != PPCS_IDLE);
    strobing = (state == PPCS_STROBE);
    for (int i = 0; i < NUM_CS; i++) begin
      next_cs_out[i] = pin_level(cfg[i].cs_polarity,
        busy && sel == IDX_W'(i) && !cfg[i].cs_off); // R02 R11
      next_cs_oe_n[i] = ~cfg[i].cs_pin_drive_on; // R03
    end
    next_pins.lane_enable_0 = pin_level(scfg.lane_enable_polarity, busy && lanes[0]); // R04
    next_pins.lane_enable_1 = pin_level(scfg.lane_enable_polarity, busy && lanes[1]); // R04
    if (style_one) begin
      // Read/write line held for the cycle, enable strobe pulses
      next_pins.read_strobe_out = pin_level(scfg.read_strobe_polarity,
        busy && !is_write); // R08
      next_pins.enable_strobe_out = pin_level(scfg.write_strobe_polarity, strobing); // R06
      next_pins.write_strobe_out = ~scfg.write_strobe_polarity; // R09
    end else begin
      // Separate strobes; enable strobe unused and held low
      next_pins.read_strobe_out = pin_level(scfg.read_strobe_polarity,
        strobing && !is_write); // R07
      next_pins.write_strobe_out = pin_level(scfg.write_strobe_polarity,
        strobing && is_write); // R05
      next_pins.enable_strobe_out = 1'b0; // R09
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= PPCS_IDLE;
      cnt <= '0;
      sel <= '0;
      is_write <= 1'b0;
      lanes <= 2'h0;
      chip_select_out <= '0;
      chip_select_oe_n <= '1;
      bus_pins <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sel <= next_sel;
      is_write <= next_is_write;
      lanes <= next_lanes;
      chip_select_out <= next_cs_out;
      chip_select_oe_n <= next_cs_oe_n;
      bus_pins <= next_pins;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  cs_off_refuse_a: assert property ( // R01
    (state == PPCS_IDLE && cmd_wr && cfg[pwdata[IDX_W-1:0]].cs_off)
      |=> (state == PPCS_IDLE && stat[1]))
    else $error("command to a chip select that is off was not refused");
  cs_idle_level_a: assert property ( // R02
    (state == PPCS_IDLE && $past(state) == PPCS_IDLE)
      |=> chip_select_out[0] == ~$past(cfg[0].cs_polarity))
    else $error("idle chip select level wrong");
  cs_pin_drive_a: assert property ( // R03
    ##1 chip_select_oe_n == ~$past({cfg[NUM_CS-1].cs_pin_drive_on, cfg[0].cs_pin_drive_on}))
    else $error("chip select drive not from port enable");
  lane_level_a: assert property ( // R04
    (state == PPCS_STROBE && lanes[0])
      |=> bus_pins.lane_enable_0 == $past(scfg.lane_enable_polarity))
    else $error("lane enable level wrong");
  wr_strobe_a: assert property ( // R05
    (state == PPCS_STROBE && is_write && !style_one)
      |=> bus_pins.write_strobe_out == $past(scfg.write_strobe_polarity))
    else $error("write strobe level wrong");
  en_strobe_a: assert property ( // R06
    (state == PPCS_STROBE && style_one)
      |=> bus_pins.enable_strobe_out == $past(scfg.write_strobe_polarity))
    else $error("enable strobe level wrong");
  rd_strobe_a: assert property ( // R07
    (state == PPCS_STROBE && !is_write && !style_one)
      |=> bus_pins.read_strobe_out == $past(scfg.read_strobe_polarity))
    else $error("read strobe level wrong");
  rw_line_a: assert property ( // R08
    (state == PPCS_ACK && is_write && style_one)
      |=> bus_pins.read_strobe_out == ~$past(scfg.read_strobe_polarity))
    else $error("read/write line level wrong");
  sep_strobe_a: assert property ( // R09
    (state == PPCS_STROBE && style_one)
      |=> bus_pins.write_strobe_out == ~$past(scfg.write_strobe_polarity))
    else $error("write strobe moved in combined style");
  ack_end_a: assert property ( // R10
    (state == PPCS_ACK && ack_level == scfg.ack_polarity)
      |=> state == PPCS_IDLE && stat[0])
    else $error("acknowledge did not end the cycle");
  own_cfg_a: assert property ( // R11
    (apb_wr && widx == 0) |=> $stable(cfg[NUM_CS-1]) || NUM_CS == 1)
    else $error("write reached another chip select");

  write_cycle_c: cover property (cmd_wr ##1 state == PPCS_STROBE ##[1:30] state == PPCS_IDLE);
  timeout_c: cover property (state == PPCS_ACK && cnt == '0 && !ack_active);
  combined_c: cover property (state == PPCS_STROBE && style_one);
endmodule : ppcs_port
`default_nettype wire

// ---- verif/ppcs_peripheral.sv ----
// Behavioural peripheral behind chip select 0, answering with an acknowledge
// Assumes the bench tells it the active levels that software programmed
`default_nettype none
module ppcs_peripheral (
  input wire logic clk,         // Port clock
  input wire logic cs_level,    // Chip select pin as seen
  input wire logic cs_active,   // Active chip select level
  input wire logic ack_active,  // Active acknowledge level
  input wire logic [3:0] delay, // Cycles from select to acknowledge
  input wire logic mute,        // Never acknowledge
  output logic ack_in           // Acknowledge toward the port
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] count = 4'h0; // Cycles selected so far
  // Count while selected, restart once released
  always @(posedge clk) begin
    if (cs_level !== cs_active) count <= 4'h0;
    else if (count != 4'hF) count <= count + 4'h1;
  end
  // Acknowledge only while selected, after the delay; otherwise inactive
  assign ack_in = (!mute && cs_level === cs_active && count >= delay) ? ack_active : ~ack_active;
endmodule : ppcs_peripheral
`default_nettype wire

// ---- verif/ppcs_port_bench.sv ----
// Self-checking bench for the chip select port: APB tasks and pin checks
// Assumes the port, its package and register header, and the peripheral model
`include "ppcs_regs.svh"
`default_nettype none
`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module ppcs_port_bench import ppcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, ack_in, ack_act, mute; // Bus, pins
  logic [7:0] paddr;               // Byte address
  logic [31:0] pwdata, prdata, rd; // Data words
  logic [1:0] cs_out, cs_oe_n;     // Chip select pins
  logic er;                        // Error seen
  ppcs_pins_type pins;             // Strobes and lanes
  int errors = 0, samples_checked = 0, cycles = 0, n;
  ppcs_port uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_out(cs_out), .chip_select_oe_n(cs_oe_n), .bus_pins(pins), .ack_in(ack_in));
  ppcs_peripheral peer (.clk(clk), .cs_level(cs_out[0]), .cs_active(1'b1),
    .ack_active(ack_act), .delay(4'h2), .mute(mute), .ack_in(ack_in));
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counts, verdict and end of run
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // One APB transfer: setup, then access until pready
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  // Poll status until the cycle engine is idle, then read it
  task wait_idle;
    for (n = 0; n < 60; n++) begin
      xfer(`PPCS_STAT_OFF, 1'b0, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask : wait_idle
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ack_act = 1'b1; mute = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // Pins take their idle levels one edge after release, seen at the next
    repeat (2) @(posedge clk);
    // Idle levels from an all-zero configuration
    `CHECK("cs idle", 2'b11, cs_out)
    `CHECK("cs drive", 2'b11, cs_oe_n)
    `CHECK("pins idle", 5'h1E, pins)
    xfer(8'h00, 1'b0, 32'h0);
    `CHECK("cfg0 reset", 32'h0, rd)
    $display("test reset done");
    // Access kinds, unmapped address, separate copies per chip select
    xfer(8'h04, 1'b1, 32'hFFFF);
    xfer(8'h04, 1'b0, 32'h0);
    `CHECK("cfg1 mask", 32'hF7E0, rd)
    xfer(8'h40, 1'b1, 32'h1);
    `CHECK("unmapped err", 1'b1, er)
    xfer(8'h04, 1'b1, 32'h8000);
    xfer(8'h00, 1'b1, 32'h7680);
    repeat (2) @(posedge clk);
    `CHECK("cs pol", 2'b10, cs_out)
    `CHECK("cs drive", 2'b10, cs_oe_n)
    `CHECK("pins inv", 5'h00, pins)
    $display("test registers done");
    // Slave-mode write on cs0, acknowledge active high
    xfer(`PPCS_CMD_OFF, 1'b1, 32'h30100);
    for (n = 0; n < 20 && pins.write_strobe_out !== 1'b1; n++) @(posedge clk);
    `CHECK("wr strobe", 1'b1, pins.write_strobe_out)
    `CHECK("cs active", 2'b11, cs_out)
    `CHECK("lanes", 2'b11, {pins.lane_enable_0, pins.lane_enable_1})
    `CHECK("rd enb", 2'b00, {pins.read_strobe_out, pins.enable_strobe_out})
    wait_idle();
    `CHECK("done", 3'b001, rd[3:1])
    xfer(`PPCS_STAT_OFF, 1'b1, 32'hE);
    // Slave-mode read on cs0, lower lane only
    xfer(`PPCS_CMD_OFF, 1'b1, 32'h10000);
    for (n = 0; n < 20 && pins.read_strobe_out !== 1'b1; n++) @(posedge clk);
    `CHECK("rd strobe", 1'b1, pins.read_strobe_out)
    `CHECK("wr quiet", 1'b0, pins.write_strobe_out)
    `CHECK("lane lo", 2'b10, {pins.lane_enable_0, pins.lane_enable_1})
    wait_idle();
    `CHECK("rd done", 3'b001, rd[3:1])
    xfer(`PPCS_STAT_OFF, 1'b1, 32'hE);
    // Command to a chip select that is off
    xfer(`PPCS_CMD_OFF, 1'b1, 32'h1);
    wait_idle();
    `CHECK("refused", 1'b1, rd[2])
    xfer(`PPCS_STAT_OFF, 1'b1, 32'hE);
    $display("test slave done");
    // Master mode, combined strobe style, acknowledge active low
    ack_act <= 1'b0;
    xfer(`PPCS_CTRL_OFF, 1'b1, 32'h1);
    xfer(8'h00, 1'b1, 32'h7700);
    xfer(`PPCS_CMD_OFF, 1'b1, 32'h0);
    for (n = 0; n < 20 && pins.enable_strobe_out !== 1'b1; n++) @(posedge clk);
    `CHECK("enb high", 1'b1, pins.enable_strobe_out)
    `CHECK("rw read", 1'b1, pins.read_strobe_out)
    `CHECK("wr held", 1'b0, pins.write_strobe_out)
    wait_idle();
    `CHECK("done low ack", 3'b001, rd[3:1])
    xfer(`PPCS_STAT_OFF, 1'b1, 32'hE);
    // Enable strobe active low, silent peripheral
    xfer(8'h00, 1'b1, 32'h7100);
    repeat (2) @(posedge clk);
    `CHECK("enb idle", 1'b1, pins.enable_strobe_out)
    `CHECK("rw idle", 1'b1, pins.read_strobe_out)
    mute <= 1'b1;
    xfer(`PPCS_CMD_OFF, 1'b1, 32'h100);
    for (n = 0; n < 20 && pins.enable_strobe_out !== 1'b0; n++) @(posedge clk);
    `CHECK("enb low", 1'b0, pins.enable_strobe_out)
    // Active level of the read/write line means read, so a write shows the other level
    `CHECK("rw write", 1'b1, pins.read_strobe_out)
    wait_idle();
    `CHECK("timeout", 3'b101, rd[3:1])
    $display("test master done");
    give_verdict();
  end
endmodule : ppcs_port_bench
`default_nettype wire
